// ===== src/fwsr_map.vh
// Register map, field positions and timing constants of the flash status poller
`ifndef FWSR_MAP_VH
`define FWSR_MAP_VH

// Register byte offsets
`define FWSR_REG_CTRL 12'h000
`define FWSR_REG_ADDR 12'h004
`define FWSR_REG_WDATA 12'h008
`define FWSR_REG_STATUS 12'h00C
`define FWSR_REG_RDATA 12'h010
`define FWSR_REG_LAST 12'h014

// Control fields
`define FWSR_CTRL_GO 0
`define FWSR_CTRL_OP_LO 1
`define FWSR_CTRL_OP_HI 3
`define FWSR_CTRL_TBIT 4

// Operation codes
`define FWSR_OP_READ 3'h0
`define FWSR_OP_WRITE 3'h1
`define FWSR_OP_POLL 3'h2
`define FWSR_OP_WINDOW 3'h3
`define FWSR_OP_RESET 3'h4

// Status fields
`define FWSR_ST_BUSY 0
`define FWSR_ST_DONE 1
`define FWSR_ST_OK 2
`define FWSR_ST_FAIL 3
`define FWSR_ST_WIN 4
`define FWSR_ST_RDY 5

// Data line positions
`define FWSR_DQ_POLL 7
`define FWSR_DQ_ACT 6
`define FWSR_DQ_FAIL 5
`define FWSR_DQ_WIN 3
`define FWSR_DQ_SECT 2

// Reset command byte written to the flash
`define FWSR_RESET_CMD 8'hF0

// Strobe phase timing
`define FWSR_PHASE_NS 80
`define FWSR_CLK_NS 40
`define FWSR_PHASE_CYC ((`FWSR_PHASE_NS + `FWSR_CLK_NS - 1) / `FWSR_CLK_NS)

`endif

// ===== src/fwsr_poller.v
// Host-side status poller for a parallel flash running program or erase
//
// Contract
// - Host starts every status check with two back-to-back full-byte reads.
// - Unchanged toggle means done; next read returns array data.
// - Toggling with failure bit high: recheck; still toggling means failure, reset.
// - Host leaving polling restarts from the first double read.
// - After any failure indication host writes the reset command.
// - Host issuing sector erases under 50 us apart may skip window bit.
// - Host confirms acceptance with poll or toggle before reading window bit; the window op reads it in one read with no poll first.
// - Host reads window bit before and after each added sector erase.
// - Host presents program address or erasing-sector address when polling.
`timescale 1ns/1ps
`include "fwsr_map.vh"

module fwsr_poller (
    // Clock, reset, enable
    input wire pclk,
    input wire presetn,
    input wire clk_en,
    // APB slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    // Flash pins
    output reg [20:0] flash_addr,
    input wire [7:0] data_lines_in,
    output reg [7:0] data_lines_out,
    output reg data_lines_oe,
    output reg flash_ce_n,
    output reg flash_oe_n,
    output reg flash_we_n,
    input wire ready_busy_pin
);

    // States
    localparam S_IDLE = 4'h0;
    localparam S_RD = 4'h1;
    localparam S_WR = 4'h2;
    localparam S_P1 = 4'h3;
    localparam S_P2 = 4'h4;
    localparam S_PCHK = 4'h5;
    localparam S_P3 = 4'h6;
    localparam S_P4 = 4'h7;
    localparam S_PFIN = 4'h8;
    localparam S_DATA = 4'h9;
    localparam S_RST = 4'hA;

    // Reload value of the phase counter, cut to the counter's width on use
    localparam [31:0] PHASE_RELOAD = `FWSR_PHASE_CYC - 1;

    // Registers
    reg [2:0] op;
    reg tbit_sel;
    reg [20:0] addr_reg;
    reg [7:0] wdata_reg;
    reg busy, done, ok, fail, win;
    reg [7:0] rdata_reg;
    reg [7:0] first_rd;
    reg [7:0] last_rd;
    reg [3:0] state;
    reg [3:0] ret_state;
    reg [1:0] cyc;
    reg cyc_write;
    reg [2:0] cnt;
    reg [2:0] rb_sync;
    reg rb_level;

    // Toggle-bit compare of two reads
    function toggled;
        input [7:0] a;
        input [7:0] b;
        input sel;
        begin
            if (sel)
                toggled = a[`FWSR_DQ_SECT] ^ b[`FWSR_DQ_SECT];
            else
                toggled = a[`FWSR_DQ_ACT] ^ b[`FWSR_DQ_ACT];
        end
    endfunction

    // Ready/busy pin synchroniser, change accepted when stages two and three agree
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rb_sync <= 3'h7;
            rb_level <= 1'b1;
        end else if (clk_en) begin
            rb_sync <= {rb_sync[1:0], ready_busy_pin};
            if (rb_sync[1] == rb_sync[2])
                rb_level <= rb_sync[2];
        end
    end

    // ==========================================================
    // APB slave
    // ==========================================================
    wire apb_wr = psel && penable && pwrite && pready;
    wire go_req = apb_wr && (paddr == `FWSR_REG_CTRL) && pwdata[`FWSR_CTRL_GO] && !busy;

    // Register writes and read data
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0;
            addr_reg <= 21'h0;
            wdata_reg <= 8'h0;
            op <= 3'h0;
            tbit_sel <= 1'b0;
        end else if (clk_en) begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && (paddr > `FWSR_REG_LAST || paddr[1:0] != 2'h0);
            // Write answers carry zero read data, as error answers do
            if (psel && !penable && pwrite)
                prdata <= 32'h0;
            if (psel && !penable && !pwrite) begin
                case (paddr)
                    `FWSR_REG_CTRL: prdata <= {27'h0, tbit_sel, op, 1'b0};
                    `FWSR_REG_ADDR: prdata <= {11'h0, addr_reg};
                    `FWSR_REG_WDATA: prdata <= {24'h0, wdata_reg};
                    `FWSR_REG_STATUS: prdata <= {26'h0, rb_level, win, fail, ok, done, busy};
                    `FWSR_REG_RDATA: prdata <= {16'h0, last_rd, rdata_reg};
                    default: prdata <= 32'h0;
                endcase
            end
            if (apb_wr && !busy) begin
                case (paddr)
                    `FWSR_REG_CTRL: begin
                        op <= pwdata[`FWSR_CTRL_OP_HI:`FWSR_CTRL_OP_LO];
                        tbit_sel <= pwdata[`FWSR_CTRL_TBIT];
                    end
                    `FWSR_REG_ADDR: addr_reg <= pwdata[20:0];
                    `FWSR_REG_WDATA: wdata_reg <= pwdata[7:0];
                    default: ;
                endcase
            end
        end
    end

    // ==========================================================
    // Flash bus cycles and polling sequence
    // ==========================================================
    wire cyc_end = (cyc == 2'h3) && (cnt == 3'h0);

    // Sequencer
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= S_IDLE;
            ret_state <= S_IDLE;
            cyc <= 2'h0;
            cyc_write <= 1'b0;
            cnt <= 3'h0;
            busy <= 1'b0;
            done <= 1'b0;
            ok <= 1'b0;
            fail <= 1'b0;
            win <= 1'b0;
            rdata_reg <= 8'h0;
            first_rd <= 8'h0;
            last_rd <= 8'h0;
            flash_addr <= 21'h0;
            data_lines_out <= 8'h0;
            data_lines_oe <= 1'b0;
            flash_ce_n <= 1'b1;
            flash_oe_n <= 1'b1;
            flash_we_n <= 1'b1;
        end else if (clk_en) begin
            // One bus cycle: setup, strobe, hold, release
            if (cyc != 2'h0) begin
                if (cnt != 3'h0) begin
                    cnt <= cnt - 3'h1;
                end else begin
                    cnt <= PHASE_RELOAD[2:0];
                    cyc <= cyc + 2'h1;
                    case (cyc)
                        2'h1: begin
                            flash_ce_n <= 1'b0;
                            flash_oe_n <= cyc_write;
                            flash_we_n <= !cyc_write;
                        end
                        2'h2: begin
                            if (!cyc_write)
                                last_rd <= data_lines_in;
                            flash_ce_n <= 1'b1;
                            flash_oe_n <= 1'b1;
                            flash_we_n <= 1'b1;
                        end
                        default: begin
                            data_lines_oe <= 1'b0;
                            cyc <= 2'h0;
                        end
                    endcase
                end
            end
            case (state)
                S_IDLE: begin
                    if (go_req) begin
                        busy <= 1'b1;
                        done <= 1'b0;
                        flash_addr <= addr_reg; // Address held for the whole op
                        case (pwdata[`FWSR_CTRL_OP_HI:`FWSR_CTRL_OP_LO])
                            `FWSR_OP_WRITE: begin
                                data_lines_out <= wdata_reg;
                                state <= S_WR;
                            end
                            `FWSR_OP_RESET: begin
                                data_lines_out <= `FWSR_RESET_CMD;
                                state <= S_WR;
                            end
                            `FWSR_OP_POLL: begin
                                ok <= 1'b0;
                                fail <= 1'b0;
                                state <= S_P1; // Fresh double read each time
                            end
                            // Window read optional for fast erase bursts
                            default: state <= S_RD; // Read also serves window
                        endcase
                        ret_state <= S_IDLE;
                        cyc <= 2'h1;
                        cnt <= PHASE_RELOAD[2:0];
                        data_lines_oe <= (pwdata[`FWSR_CTRL_OP_HI:`FWSR_CTRL_OP_LO]
                            == `FWSR_OP_WRITE) || (pwdata[`FWSR_CTRL_OP_HI:`FWSR_CTRL_OP_LO]
                            == `FWSR_OP_RESET);
                        cyc_write <= (pwdata[`FWSR_CTRL_OP_HI:`FWSR_CTRL_OP_LO]
                            == `FWSR_OP_WRITE) || (pwdata[`FWSR_CTRL_OP_HI:`FWSR_CTRL_OP_LO]
                            == `FWSR_OP_RESET);
                    end
                end
                S_RD, S_WR, S_DATA, S_RST: begin
                    if (cyc_end) begin
                        if (state == S_RD || state == S_DATA) begin
                            // Byte latched while the strobes were still low
                            rdata_reg <= last_rd;
                            win <= last_rd[`FWSR_DQ_WIN]; // Window bit sample
                        end
                        busy <= 1'b0;
                        done <= 1'b1;
                        state <= S_IDLE;
                    end
                end
                S_P1: begin
                    if (cyc_end) begin
                        first_rd <= last_rd; // First of two reads
                        cyc <= 2'h1;
                        cyc_write <= 1'b0;
                        state <= S_P2;
                    end
                end
                S_P2: begin
                    if (cyc_end)
                        state <= S_PCHK;
                end
                S_PCHK: begin
                    if (!toggled(first_rd, last_rd, tbit_sel)) begin
                        ok <= 1'b1;
                        cyc <= 2'h1;
                        cyc_write <= 1'b0;
                        state <= S_DATA; // Stopped: next read is array data
                    end else if (last_rd[`FWSR_DQ_FAIL]) begin
                        cyc <= 2'h1;
                        cyc_write <= 1'b0;
                        state <= S_P3; // Failure bit high: recheck
                    end else begin
                        cyc <= 2'h1;
                        cyc_write <= 1'b0;
                        state <= S_P1; // Keep polling with a fresh pair
                    end
                end
                S_P3: begin
                    if (cyc_end) begin
                        first_rd <= last_rd;
                        cyc <= 2'h1;
                        state <= S_P4;
                    end
                end
                S_P4: begin
                    if (cyc_end)
                        state <= S_PFIN;
                end
                S_PFIN: begin
                    cyc <= 2'h1;
                    if (!toggled(first_rd, last_rd, tbit_sel)) begin
                        ok <= 1'b1;
                        cyc_write <= 1'b0;
                        state <= S_DATA; // Late stop counts as success
                    end else begin
                        fail <= 1'b1;
                        cyc_write <= 1'b1;
                        data_lines_oe <= 1'b1;
                        data_lines_out <= `FWSR_RESET_CMD; // Failure: reset command
                        state <= S_RST;
                    end
                end
                default: state <= S_IDLE;
            endcase
        end
    end

endmodule // fwsr_poller

// ===== testbench/fwsr_flash_model.sv
// Behavioural flash device answering status and array reads
`timescale 1ns/1ps
module fwsr_flash_model (
    // Flash pins
    input wire logic ce_n,
    input wire logic oe_n,
    input wire logic we_n,
    input wire logic [7:0] din,
    output logic [7:0] dout,
    output logic rdy,
    // Scenario knobs
    input wire logic load,
    input wire logic [3:0] busy_in,
    input wire logic fail_in,
    input wire logic win_in
);
    logic [7:0] mem = 8'hA5;
    logic [7:0] last = 8'h00;
    logic [3:0] left = 4'h0;
    logic fl = 1'b0;
    logic tg = 1'b0;
    logic stat;
    logic rsel;
    logic wsel;
    logic [7:0] cur;
    // ====
    // Status byte while busy, else array
    assign stat = (left != 4'h0) || fl;
    // Window bit is a knob; poll bit reads 0 as in erase
    assign cur = stat ? {1'b0, tg, fl, 1'b0, win_in, tg, 2'b00} : mem;
    assign rsel = !ce_n && !oe_n;
    assign wsel = !ce_n && !we_n;
    assign dout = rsel ? cur : ~last; // Released lines carry no stale value
    assign rdy = !stat;
    // Both toggles invert per read
    always @(negedge rsel) begin
        last <= cur;
        if (stat) tg <= ~tg;
        if (left != 4'h0) left <= left - 4'h1;
    end
    // Reset command, or program that only clears bits
    always @(negedge wsel) begin
        if (din == 8'hF0) begin
            fl <= 1'b0;
            left <= 4'h0;
        end else if (^din !== 1'bx) mem <= mem & din; // Skip the power-up strobe glitch
    end
    // Start of a scenario
    always @(posedge load) begin
        left <= busy_in;
        fl <= fail_in;
        tg <= 1'b0;
    end
endmodule // fwsr_flash_model

// ===== testbench/fwsr_poller_properties.sv
// Port checker of the flash status poller
`timescale 1ns/1ps
module fwsr_poller_props (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Flash pins
    input wire logic [20:0] flash_addr,
    input wire logic data_lines_oe,
    input wire logic flash_ce_n,
    input wire logic flash_oe_n,
    input wire logic flash_we_n
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ====
    // Read strobe low two clocks
    sequence s_strobe2;
        !flash_oe_n ##1 flash_oe_n;
    endsequence
    property p_rd_width; $fell(flash_oe_n) |=> s_strobe2; endproperty
    property p_setup_ready; psel && !penable |=> pready; endproperty
    property p_ready_pulse; pready |=> !pready; endproperty
    property p_err_zero; pslverr |-> pready && prdata == 32'h0; endproperty
    property p_ce_frame; !flash_oe_n || !flash_we_n |-> !flash_ce_n; endproperty
    property p_addr_hold; !flash_ce_n |-> $stable(flash_addr); endproperty
    property p_wr_drive; !flash_we_n |-> data_lines_oe && flash_oe_n; endproperty
    property p_no_clash; data_lines_oe |-> flash_oe_n; endproperty
    a_rd_width: assert property (p_rd_width) else $error("read strobe width");
    a_setup_ready: assert property (p_setup_ready) else $error("no ready after setup");
    a_ready_pulse: assert property (p_ready_pulse) else $error("ready too long");
    a_err_zero: assert property (p_err_zero) else $error("error read not zero");
    a_ce_frame: assert property (p_ce_frame) else $error("strobe without select");
    a_addr_hold: assert property (p_addr_hold) else $error("address moved");
    a_wr_drive: assert property (p_wr_drive) else $error("write not driven");
    a_no_clash: assert property (p_no_clash) else $error("data line clash");
endmodule // fwsr_poller_props

bind fwsr_poller fwsr_poller_props u_props (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .flash_addr(flash_addr), .data_lines_oe(data_lines_oe), .flash_ce_n(flash_ce_n),
    .flash_oe_n(flash_oe_n), .flash_we_n(flash_we_n));

// ===== testbench/fwsr_poller_tb_top.sv
// Self-checking bench of the flash status poller
`timescale 1ns/1ps
`include "fwsr_map.vh"
module fwsr_poller_tb_top;
    typedef struct {logic [2:0] op; logic tb; logic [3:0] bz; logic w; logic [3:0] es;
        logic [7:0] er;} fwsr_row_t;
    fwsr_row_t rows [5];
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic load = 1'b0;
    logic [3:0] busy = 4'h0;
    logic fail = 1'b0;
    logic win = 1'b0;
    logic [31:0] rd;
    logic er;
    int n_mismatch = 0;
    int num_checks = 0;
    wire [31:0] prdata;
    wire [20:0] flash_addr;
    wire [7:0] hout, fout, dq;
    wire pready, pslverr, data_lines_oe, flash_ce_n, flash_oe_n, flash_we_n, rdy;
    assign dq = data_lines_oe ? hout : fout; // Resolved data lines
    fwsr_poller dut (.pclk(pclk), .presetn(presetn), .clk_en(1'b1), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .flash_addr(flash_addr), .data_lines_in(dq),
        .data_lines_out(hout), .data_lines_oe(data_lines_oe), .flash_ce_n(flash_ce_n),
        .flash_oe_n(flash_oe_n), .flash_we_n(flash_we_n), .ready_busy_pin(rdy));
    fwsr_flash_model u_flash (.ce_n(flash_ce_n), .oe_n(flash_oe_n), .we_n(flash_we_n),
        .din(dq), .dout(fout), .rdy(rdy), .load(load), .busy_in(busy), .fail_in(fail),
        .win_in(win));
    // ====
    // Clock and helpers
    initial forever #20 pclk = ~pclk;
    task automatic results();
        $display("Checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 20) begin
            n_mismatch++;
            results();
        end
    endtask
    task automatic set_flash(input logic [3:0] bz, input logic f, input logic w);
        @(posedge pclk);
        busy <= bz;
        fail <= f;
        win <= w;
        load <= 1'b1;
        @(posedge pclk);
        load <= 1'b0;
        repeat (4) @(posedge pclk);
    endtask
    task automatic run_op(input logic [2:0] op, input logic tb);
        int n;
        apb(1'b1, `FWSR_REG_CTRL, {27'h0, tb, op, 1'b1});
        n = 0;
        do begin
            apb(1'b0, `FWSR_REG_STATUS, 32'h0);
            n++;
        end while (rd[`FWSR_ST_BUSY] !== 1'b0 && n < 300);
        if (n >= 300) begin
            n_mismatch++;
            results();
        end
    endtask
    // ====
    // Main sequence
    initial begin
        rows[0] = '{`FWSR_OP_READ, 1'b0, 4'h0, 1'b0, 4'h9, 8'hA5};
        rows[1] = '{`FWSR_OP_POLL, 1'b0, 4'h0, 1'b0, 4'h9, 8'hA5};
        rows[2] = '{`FWSR_OP_POLL, 1'b0, 4'h5, 1'b0, 4'h9, 8'hA5};
        rows[3] = '{`FWSR_OP_POLL, 1'b1, 4'h4, 1'b0, 4'h9, 8'hA5};
        rows[4] = '{`FWSR_OP_WINDOW, 1'b0, 4'h2, 1'b1, 4'h5, 8'h08};
        repeat (10) @(posedge pclk);
        chk(prdata, 32'h0);
        chk({28'h0, flash_ce_n, flash_oe_n, flash_we_n, data_lines_oe}, 32'hE);
        presetn <= 1'b1;
        for (int i = 0; i < 5; i++) begin
            set_flash(rows[i].bz, 1'b0, rows[i].w);
            run_op(rows[i].op, rows[i].tb);
            chk({28'h0, rd[5], rd[4], rd[3], rd[1]}, {28'h0, rows[i].es});
            apb(1'b0, `FWSR_REG_RDATA, 32'h0);
            chk({24'h0, rd[7:0]}, {24'h0, rows[i].er});
            $display("Row %0d done", i);
        end
        // Failure keeps toggling, then reset brings back array data
        set_flash(4'h0, 1'b1, 1'b0);
        run_op(`FWSR_OP_POLL, 1'b0);
        chk({30'h0, rd[3], rd[1]}, 32'h3);
        run_op(`FWSR_OP_READ, 1'b0);
        apb(1'b0, `FWSR_REG_RDATA, 32'h0);
        chk({24'h0, rd[7:0]}, 32'hA5);
        $display("Failure test done");
        // Program byte, then read back and hit an unmapped word
        apb(1'b1, `FWSR_REG_ADDR, 32'h001ABCDE);
        apb(1'b1, `FWSR_REG_WDATA, 32'h3C);
        run_op(`FWSR_OP_WRITE, 1'b0);
        run_op(`FWSR_OP_READ, 1'b0);
        apb(1'b0, `FWSR_REG_RDATA, 32'h0);
        chk({24'h0, rd[7:0]}, 32'h24);
        chk({11'h0, flash_addr}, 32'h001ABCDE);
        apb(1'b0, 12'h020, 32'h0);
        chk({er, rd[30:0]}, 32'h80000000);
        $display("Write and bus tests done");
        results();
    end
endmodule // fwsr_poller_tb_top
